// File: rtl/ied_pkg.sv
// Purpose: shared constants and types of the interrupt and exception dispatch unit
// Assumes: 8-bit vector numbers, 256-entry handler table
// Notes:   vector numbers are the fixed assignments of the core's exception sources
package ied_pkg;

  // vector width and fixed vector numbers
  localparam int         VEC_W          = 8;
  localparam logic [7:0] VEC_DEBUG      = 8'h01;
  localparam logic [7:0] VEC_NMI        = 8'h02;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
  localparam logic [7:0] VEC_ILLEGAL    = 8'h06;
  localparam logic [7:0] VEC_COPROC_NA  = 8'h07;
  localparam logic [7:0] VEC_DOUBLE     = 8'h08;
  localparam logic [7:0] VEC_COPROC_OVR = 8'h09;
  localparam logic [7:0] VEC_BAD_TSS    = 8'h0A;
  localparam logic [7:0] VEC_SEG_ABSENT = 8'h0B;
  localparam logic [7:0] VEC_PROTECT    = 8'h0D;
  localparam logic [7:0] VEC_XLATE      = 8'h0E;

  // first vector number free for the system designer
  localparam logic [7:0] VEC_USER_FIRST = 8'h20;

  // reset values
  localparam logic       IRQ_FLAG_RST   = 1'b0;

  // depth of the saved enable-flag stack (nesting depth)
  localparam int         FLAG_STACK_DEPTH = 8;

  // width of the synchronised pin group: nmi, maskable, ack valid, ack vector
  localparam int         PIN_SYNC_W     = 11;

  // how an event is reported and where its return address points
  typedef enum logic [1:0] {
    CLS_FAULT,
    CLS_TRAP,
    CLS_ABORT,
    CLS_MASKABLE_REQUEST_LINE
  } ied_class_t;

  // which kind of source won the boundary
  typedef enum logic [2:0] {
    K_NONE,
    K_DBG,
    K_NMI,
    K_MASKABLE_REQUEST_LINE,
    K_EXC,
    K_SWI
  } ied_kind_t;

endpackage

// File: rtl/ied_sync2.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: multi-bit data is held stable around its valid strobe
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
module ied_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // asynchronous pins in, synchronised copy out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // first stage, metastability catcher
  logic [WIDTH-1:0] sync_q;  // second stage, safe to read

  // both stages clear on reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: rtl/ied_flag_stack.sv
// Purpose: lifo of saved interrupt-enable flags, one entry per nested entry
// Assumes: push and pop are never asked in the same cycle
// Notes:   top of stack comes straight out of a register
`timescale 1ns/10ps
module ied_flag_stack #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // stack operations
  input  wire logic push,
  input  wire logic pop,
  input  wire logic push_bit,
  // registered top entry
  output logic      top_bit
);

  logic [DEPTH-1:0] stk_q;  // entry 0 is the top

  // shift in on push, shift out on pop; the oldest entry falls off when full
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stk_q <= '0;
    end else if (push) begin
      stk_q <= {stk_q[DEPTH-2:0], push_bit};
    end else if (pop) begin
      stk_q <= {1'b0, stk_q[DEPTH-1:1]};
    end
  end

  assign top_bit = stk_q[0];

endmodule

// File: rtl/ied_dispatch.sv
// Purpose: interrupt and exception dispatch; picks one event per instruction
//          boundary, latches vector and class, and runs the handler entry
// Assumes: core stalls while dispatch_busy is high; core-side inputs are on mclk
// Notes:   nmi, maskable line and acknowledge vector come from pins and are synchronised
`timescale 1ns/10ps
module ied_dispatch (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // instruction boundary from the core
  input  wire logic                   insn_boundary,
  // exception sources, valid at the boundary
  input  wire logic                   illegal_op,
  input  wire logic                   coproc_unavail,
  input  wire logic                   double_fault,
  input  wire logic                   coproc_overrun,
  input  wire logic                   xlate_fail,
  input  wire logic                   seg_absent,
  input  wire logic                   protect_viol,
  input  wire logic                   overflow_op,
  input  wire logic                   bad_task_state_segment,
  input  wire logic                   dbg_trap,
  input  wire logic                   dbg_fault,
  // software vector calls
  input  wire logic                   swi_call,
  input  wire logic [7:0]             swi_vector,
  input  wire logic                   swi_breakpoint,
  // flag instructions
  input  wire logic                   handler_return_op,
  input  wire logic                   flag_set_op,
  input  wire logic                   flag_clr_op,
  // pins from the external interrupt controller
  input  wire logic                   maskable_request_line,
  input  wire logic                   nmi_request,
  input  wire logic                   ack_vector_valid,
  input  wire logic [7:0]             ack_vector,
  // acknowledge to the controller
  output logic                        int_ack,
  // dispatch result to the core
  output logic                        dispatch_busy,
  output logic                        dispatch_valid,
  output logic [7:0]                  dispatch_vector,
  output ied_pkg::ied_class_t         dispatch_class,
  output logic                        ret_at_faulting,
  output logic                        dbg_both,
  // status
  output logic                        irq_enable_flag,
  output logic                        nmi_active,
  output logic                        nmi_pending
);

  // dispatch sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACK,
    ST_ENTER
  } ied_state_t;

  // local views of the package source kinds, since nothing is imported
  typedef ied_pkg::ied_kind_t ied_kind_t;
  localparam ied_kind_t K_NONE = ied_pkg::K_NONE;  // no source
  localparam ied_kind_t K_DBG  = ied_pkg::K_DBG;   // debug event
  localparam ied_kind_t K_NMI  = ied_pkg::K_NMI;   // non-maskable request
  localparam ied_kind_t K_MASKABLE_REQUEST_LINE = ied_pkg::K_MASKABLE_REQUEST_LINE;  // maskable request
  localparam ied_kind_t K_EXC  = ied_pkg::K_EXC;   // internal exception
  localparam ied_kind_t K_SWI  = ied_pkg::K_SWI;   // software vector call

  ied_state_t          state_q;           // sequencer state
  logic [10:0]         pin_s;             // synchronised pin group
  logic                nmi_s;             // synchronised nmi level
  logic                maskable_request_line_s;            // synchronised maskable line
  logic                ackv_s;            // synchronised acknowledge valid
  logic [7:0]          ackvec_s;          // synchronised acknowledge vector
  logic                nmi_dly_q;         // nmi level one cycle late, for edge
  logic                nmi_latch_q;       // nmi seen and not yet serviced
  logic                nmi_active_q;      // nmi handler running
  logic                irq_flag_q;        // maskable enable flag
  logic                stk_top;           // saved flag at top of stack
  logic                take;              // an event is taken this cycle
  logic                nmi_ok;            // nmi may be serviced now
  logic                maskable_request_line_ok;           // maskable request may be serviced now
  ied_kind_t           sel_kind;          // winning source kind
  logic [7:0]          sel_vec;           // winning vector
  ied_pkg::ied_class_t sel_cls;           // winning class
  ied_kind_t           kind_q;            // latched kind
  logic [7:0]          vec_q;             // latched vector
  ied_pkg::ied_class_t cls_q;             // latched class
  logic                both_q;            // latched debug trap-and-fault
  logic                int_ack_q;         // acknowledge held to controller
  logic                busy_q;            // entry sequence in progress
  logic                valid_q;           // one-cycle dispatch strobe
  logic                ret_q;             // return address at faulting insn
  logic                nmi_pend_q;        // registered pending-nmi status

  // pins pass two flops before any logic reads them
  ied_sync2 #(
    .WIDTH (ied_pkg::PIN_SYNC_W)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({nmi_request, maskable_request_line, ack_vector_valid, ack_vector}),
    .sync_out (pin_s)
  );

  assign nmi_s    = pin_s[10];
  assign maskable_request_line_s   = pin_s[9];
  assign ackv_s   = pin_s[8];
  assign ackvec_s = pin_s[7:0];

  // saved enable flags for nested handlers
  ied_flag_stack #(
    .DEPTH (ied_pkg::FLAG_STACK_DEPTH)
  ) u_flag_stack (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .push     (state_q == ST_ENTER),
    .pop      (handler_return_op && state_q == ST_IDLE),
    .push_bit (irq_flag_q),
    .top_bit  (stk_top)
  );

  // external requests only count at an idle boundary
  assign nmi_ok  = nmi_latch_q && !nmi_active_q;
  assign maskable_request_line_ok = maskable_request_line_s && irq_flag_q;
  assign take    = insn_boundary && state_q == ST_IDLE && sel_kind != K_NONE;

  // priority pick: debug first, then nmi, maskable, then one exception
  always_comb begin
    sel_kind = K_NONE;
    sel_vec  = 8'h00;
    sel_cls  = ied_pkg::CLS_FAULT;
    if (dbg_trap || dbg_fault) begin
      sel_kind = K_DBG;
      sel_vec  = ied_pkg::VEC_DEBUG;
      sel_cls  = dbg_trap ? ied_pkg::CLS_TRAP : ied_pkg::CLS_FAULT;
    end else if (nmi_ok) begin
      sel_kind = K_NMI;
      sel_vec  = ied_pkg::VEC_NMI;
      sel_cls  = ied_pkg::CLS_MASKABLE_REQUEST_LINE;
    end else if (maskable_request_line_ok) begin
      sel_kind = K_MASKABLE_REQUEST_LINE;
      sel_cls  = ied_pkg::CLS_MASKABLE_REQUEST_LINE;
    end else if (double_fault) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_DOUBLE;
      sel_cls  = ied_pkg::CLS_ABORT;
    end else if (seg_absent) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_SEG_ABSENT;
    end else if (protect_viol) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_PROTECT;
    end else if (xlate_fail) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_XLATE;
    end else if (illegal_op) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_ILLEGAL;
    end else if (coproc_unavail) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_COPROC_NA;
    end else if (coproc_overrun) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_COPROC_OVR;
      sel_cls  = ied_pkg::CLS_ABORT;
    end else if (bad_task_state_segment) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_BAD_TSS;
    end else if (overflow_op) begin
      sel_kind = K_EXC;
      sel_vec  = ied_pkg::VEC_OVERFLOW;
      sel_cls  = ied_pkg::CLS_TRAP;
    end else if (swi_breakpoint) begin
      sel_kind = K_SWI;
      sel_vec  = ied_pkg::VEC_BREAKPOINT;
      sel_cls  = ied_pkg::CLS_TRAP;
    end else if (swi_call) begin
      sel_kind = K_SWI;
      sel_vec  = swi_vector;
      sel_cls  = ied_pkg::CLS_TRAP;
    end
  end

  // sequencer: idle -> (ack) -> enter -> idle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= (sel_kind == K_MASKABLE_REQUEST_LINE) ? ST_ACK : ST_ENTER;
          end
        end
        ST_ACK: begin
          if (ackv_s) begin
            state_q <= ST_ENTER;
          end
        end
        ST_ENTER: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // latch exactly one winner per boundary; the rest stay for a later attempt
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      kind_q <= K_NONE;
      vec_q  <= 8'h00;
      cls_q  <= ied_pkg::CLS_FAULT;
      both_q <= 1'b0;
    end else if (take) begin
      kind_q <= sel_kind;
      vec_q  <= sel_vec;
      cls_q  <= sel_cls;
      both_q <= dbg_trap && dbg_fault;
    end else if (state_q == ST_ACK && ackv_s) begin
      vec_q  <= ackvec_s;
    end
  end

  // acknowledge held from a maskable take until the controller answers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      int_ack_q <= 1'b0;
    end else if (take && sel_kind == K_MASKABLE_REQUEST_LINE) begin
      int_ack_q <= 1'b1;
    end else if (state_q == ST_ACK && ackv_s) begin
      int_ack_q <= 1'b0;
    end
  end

  // busy from take until the dispatch strobe; strobe lasts one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q  <= 1'b0;
      valid_q <= 1'b0;
      ret_q   <= 1'b0;
    end else begin
      valid_q <= (state_q == ST_ENTER);
      if (take) begin
        busy_q <= 1'b1;
      end else if (state_q == ST_ENTER) begin
        busy_q <= 1'b0;
      end
      if (state_q == ST_ENTER) begin
        ret_q <= (cls_q == ied_pkg::CLS_FAULT);
      end
    end
  end

  // enable flag: entry clears, return restores, core instructions set or clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_flag_q <= ied_pkg::IRQ_FLAG_RST;
    end else if (state_q == ST_ENTER) begin
      irq_flag_q <= 1'b0;
    end else if (handler_return_op && state_q == ST_IDLE) begin
      irq_flag_q <= stk_top;
    end else if (flag_set_op) begin
      irq_flag_q <= 1'b1;
    end else if (flag_clr_op) begin
      irq_flag_q <= 1'b0;
    end
  end

  // nmi edge latch; a new edge wins over the clear at service
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nmi_dly_q   <= 1'b0;
      nmi_latch_q <= 1'b0;
    end else begin
      nmi_dly_q <= nmi_s;
      if (nmi_s && !nmi_dly_q) begin
        nmi_latch_q <= 1'b1;
      end else if (take && sel_kind == K_NMI) begin
        nmi_latch_q <= 1'b0;
      end
    end
  end

  // nmi handler running from entry until the next handler return
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nmi_active_q <= 1'b0;
    end else if (state_q == ST_ENTER && kind_q == K_NMI) begin
      nmi_active_q <= 1'b1;
    end else if (handler_return_op && state_q == ST_IDLE) begin
      nmi_active_q <= 1'b0;
    end
  end

  // pending status registered so the output comes from a flop; one cycle late
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= nmi_latch_q && nmi_active_q;
    end
  end

  // outputs straight from flops
  assign int_ack         = int_ack_q;
  assign dispatch_busy   = busy_q;
  assign dispatch_valid  = valid_q;
  assign dispatch_vector = vec_q;
  assign dispatch_class  = cls_q;
  assign ret_at_faulting = ret_q;
  assign dbg_both        = both_q;
  assign irq_enable_flag = irq_flag_q;
  assign nmi_active      = nmi_active_q;
  assign nmi_pending     = nmi_pend_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_take_direct;
    take && sel_kind != K_MASKABLE_REQUEST_LINE;
  endsequence

  sequence s_entry;
    busy_q && !valid_q ##1 valid_q && !busy_q;
  endsequence

  chk_entry_timing: assert property (s_take_direct |=> s_entry)
    else $error("direct take did not dispatch two cycles later");

  chk_illegal_fault: assert property (
    valid_q && kind_q == K_EXC && vec_q == ied_pkg::VEC_ILLEGAL |-> cls_q == ied_pkg::CLS_FAULT && ret_q)
    else $error("illegal opcode not a restartable fault");

  chk_overrun_abort: assert property (
    valid_q && kind_q == K_EXC && vec_q == ied_pkg::VEC_COPROC_OVR |-> cls_q == ied_pkg::CLS_ABORT && !ret_q)
    else $error("coprocessor overrun not an abort");

  chk_overflow_trap: assert property (
    take && sel_kind == K_EXC && !double_fault && !seg_absent && !protect_viol && !xlate_fail
      && !illegal_op && !coproc_unavail && !coproc_overrun && !bad_task_state_segment && overflow_op
    |-> ##2 valid_q && vec_q == ied_pkg::VEC_OVERFLOW && !ret_q)
    else $error("overflow trap vector or return address wrong");

  chk_flag_entry: assert property (valid_q |-> !irq_flag_q)
    else $error("enable flag still set after handler entry");

  chk_return_restore: assert property (
    handler_return_op && state_q == ST_IDLE |=> irq_flag_q == $past(stk_top))
    else $error("return did not restore saved enable flag");

  chk_nmi_vector: assert property (
    valid_q && kind_q == K_NMI |-> vec_q == ied_pkg::VEC_NMI && !int_ack_q && $past(!int_ack_q, 2))
    else $error("nmi dispatched with wrong vector or acknowledge");

  chk_nmi_block: assert property (
    take && sel_kind == K_NMI |-> !nmi_active_q)
    else $error("nmi taken while nmi handler active");

  chk_nmi_first: assert property (take && nmi_ok |=> kind_q == K_NMI || kind_q == K_DBG)
    else $error("maskable taken ahead of nmi");

  chk_ack_vector: assert property (
    state_q == ST_ACK && ackv_s |=> ##1 valid_q && vec_q == $past(ackvec_s, 2))
    else $error("acknowledged vector not dispatched");

  chk_maskable_request_line_gate: assert property (take && sel_kind == K_MASKABLE_REQUEST_LINE |-> maskable_request_line_s && irq_flag_q)
    else $error("maskable taken while line low or flag clear");

endmodule

// File: tb/ied_pic_model.sv
// Purpose: behavioural interrupt controller facing the dispatch unit
// Assumes: a raise pulse asks for one maskable request carrying vec
// Notes:   ack vector bus shows inverted junk while not valid
`timescale 1ns/10ps
module ied_pic_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // bench control
  input  wire logic       raise,
  input  wire logic [7:0] vec,
  // pins toward the dispatch unit
  input  wire logic       int_ack,
  output logic            maskable_request_line,
  output logic            ack_vector_valid,
  output logic [7:0]      ack_vector
);
  int wait_q;  // cycles since acknowledge seen

  // request line held high until the answered acknowledge is withdrawn
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      maskable_request_line <= 1'b0;
      ack_vector_valid      <= 1'b0;
      ack_vector            <= 8'h00;
      wait_q                <= 0;
    end else begin
      if (raise) begin
        maskable_request_line <= 1'b1;
      end
      // answer the acknowledge after a short think time
      if (maskable_request_line && int_ack && !ack_vector_valid) begin
        wait_q <= wait_q + 1;
        if (wait_q >= DELAY) begin
          ack_vector_valid <= 1'b1;
          ack_vector       <= vec;
        end
      end
      // acknowledge consumed: release line, scramble the bus
      if (ack_vector_valid && !int_ack) begin
        ack_vector_valid      <= 1'b0;
        maskable_request_line <= 1'b0;
        ack_vector            <= ~ack_vector;
        wait_q                <= 0;
      end
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench of the dispatch unit
// Assumes: one core-side boundary per call of fire
// Notes:   vector and class are checked in the dispatch_valid cycle
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  // core side stimulus
  logic        mclk, sys_rst, insn_boundary, pic_raise;
  logic [12:0] src;
  logic [7:0]  swi_n, pic_vec;
  logic [3:0]  ops;
  // pins and results
  logic        mrl, avv, int_ack, dispatch_busy, dispatch_valid, ret_at_faulting;
  logic        dbg_both, irq_enable_flag, nmi_active, nmi_pending;
  logic [7:0]  av, dispatch_vector;
  ied_pkg::ied_class_t dispatch_class;
  int          miscompares, tests_run;
  // expected vector and class per source bit
  logic [7:0]  vt [13] = '{8'ha5, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0e, 8'h0b, 8'h0d, 8'h04, 8'h0a, 8'h01, 8'h01};
  ied_pkg::ied_class_t ct [13] = '{ied_pkg::CLS_TRAP, ied_pkg::CLS_TRAP, ied_pkg::CLS_FAULT, ied_pkg::CLS_FAULT,
    ied_pkg::CLS_ABORT, ied_pkg::CLS_ABORT, ied_pkg::CLS_FAULT, ied_pkg::CLS_FAULT, ied_pkg::CLS_FAULT,
    ied_pkg::CLS_TRAP, ied_pkg::CLS_FAULT, ied_pkg::CLS_TRAP, ied_pkg::CLS_FAULT};

  ied_dispatch ied_dispatch_i (
    .mclk(mclk), .sys_rst(sys_rst), .insn_boundary(insn_boundary),
    .swi_call(src[0]), .swi_breakpoint(src[1]), .illegal_op(src[2]), .coproc_unavail(src[3]),
    .double_fault(src[4]), .coproc_overrun(src[5]), .xlate_fail(src[6]), .seg_absent(src[7]),
    .protect_viol(src[8]), .overflow_op(src[9]), .bad_task_state_segment(src[10]),
    .dbg_trap(src[11]), .dbg_fault(src[12]), .swi_vector(swi_n),
    .handler_return_op(ops[0]), .flag_set_op(ops[1]), .flag_clr_op(ops[2]),
    .maskable_request_line(mrl), .nmi_request(ops[3]), .ack_vector_valid(avv), .ack_vector(av),
    .int_ack(int_ack), .dispatch_busy(dispatch_busy), .dispatch_valid(dispatch_valid),
    .dispatch_vector(dispatch_vector), .dispatch_class(dispatch_class), .ret_at_faulting(ret_at_faulting),
    .dbg_both(dbg_both), .irq_enable_flag(irq_enable_flag), .nmi_active(nmi_active), .nmi_pending(nmi_pending));

  ied_pic_model ied_pic_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .raise(pic_raise), .vec(pic_vec), .int_ack(int_ack),
    .maskable_request_line(mrl), .ack_vector_valid(avv), .ack_vector(av));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one boundary cycle with the given sources
  task automatic fire(input logic [12:0] s, input logic [7:0] n);
    @(posedge mclk);
    insn_boundary <= 1'b1;
    src           <= s;
    swi_n         <= n;
    @(posedge mclk);
    insn_boundary <= 1'b0;
    src           <= 13'h0000;
  endtask

  // one-cycle pulse on a flag instruction or the nmi pin, then settle
  task automatic op(input int k);
    @(posedge mclk);
    ops[k] <= 1'b1;
    @(posedge mclk);
    ops[k] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // controller asks for a maskable request
  task automatic req();
    @(posedge mclk);
    pic_raise <= 1'b1;
    @(posedge mclk);
    pic_raise <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // wait for the dispatch pulse and judge it
  task automatic expect_disp(input logic [7:0] v, input ied_pkg::ied_class_t c);
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk);
      if (dispatch_valid === 1'b1) break;
    end
    `CHK(dispatch_valid, 1'b1)
    `CHK(dispatch_busy, 1'b0)
    `CHK(dispatch_vector, v)
    `CHK(dispatch_class, c)
    `CHK(ret_at_faulting, (c == ied_pkg::CLS_FAULT))
  endtask

  // nothing may be dispatched or acknowledged for n cycles
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge mclk);
      if (dispatch_valid !== 1'b0 || int_ack !== 1'b0) k++;
    end
    `CHK(k, 0)
  endtask

  // every exception source alone, then contended boundaries
  task automatic t_exc();
    for (int b = 0; b < 13; b++) begin
      fire(13'h0001 << b, 8'ha5);
      expect_disp(vt[b], ct[b]);
    end                            // per-source vectors also
    fire(13'h0001, 8'hff);
    expect_disp(8'hff, ied_pkg::CLS_TRAP);
    fire(13'h1800, 8'h00);
    expect_disp(8'h01, ied_pkg::CLS_TRAP);
    `CHK(dbg_both, 1'b1)
    fire(13'h0104, 8'h00);
    expect_disp(8'h0d, ied_pkg::CLS_FAULT);
    fire(13'h0014, 8'h00);
    expect_disp(8'h08, ied_pkg::CLS_ABORT);
  endtask

  // maskable request: boundary sampling, masking, flag save and restore
  task automatic t_mask();
    op(1);
    req();
    quiet(10);
    fire(13'h0000, 8'h00);
    expect_disp(8'h47, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    `CHK(irq_enable_flag, 1'b0)
    op(0);
    `CHK(irq_enable_flag, 1'b1)
    op(2);
    req();
    fire(13'h0000, 8'h00);
    quiet(20);
    op(1);
    fire(13'h0000, 8'h00);
    expect_disp(8'h47, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    op(0);
  endtask

  // non-maskable: fixed vector, pending latch, priority over maskable
  task automatic t_nmi();
    op(3);
    fire(13'h0000, 8'h00);
    expect_disp(8'h02, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    `CHK(nmi_active, 1'b1)
    op(3);
    `CHK(nmi_pending, 1'b1)
    fire(13'h0000, 8'h00);
    quiet(10);
    op(0);
    fire(13'h0000, 8'h00);
    expect_disp(8'h02, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    op(0);
    op(1);
    req();
    op(3);
    fire(13'h0000, 8'h00);
    expect_disp(8'h02, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    `CHK(irq_enable_flag, 1'b0)
    fire(13'h0000, 8'h00);
    quiet(10);
    op(0);
    fire(13'h0000, 8'h00);
    expect_disp(8'h47, ied_pkg::CLS_MASKABLE_REQUEST_LINE);
    op(0);
  endtask

  // verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    miscompares   = 0;
    tests_run     = 0;
    sys_rst       = 1'b1;
    insn_boundary = 1'b0;
    src           = 13'h0000;
    swi_n         = 8'h00;
    ops           = 4'h0;
    pic_raise     = 1'b0;
    pic_vec       = 8'h47;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_exc();
    t_mask();
    t_nmi();
    end_sim();
  end

  // watchdog well beyond the few hundred cycles needed
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule
